// ===== rtl/eight_bit_gpio_port.sv
// Eight-pin general-purpose port with direction and level registers and strap-selected pads.
// Operation
// - Eight pins map pin 0 to register bit 0 through pin 7 to bit 7.
// - The direction register answers at 0x3400 and the level register at 0x3401 on the bus.
// - Pins three and five share pads with the serial transmit clock and frame sync.
// - A low strap during reset makes the shared pads port pins three and five.
// - A high strap during reset makes the shared pads serial clock and frame sync.
// - The pad function is fixed at reset release from the strap seen during reset.
// - Direction bits are read/write, reset to zero, zero meaning input and one output.
// - Direction bits 15 to 8 read as zero.
// - An input pin reads back as its pin level.
// - An output pin is driven to the value written to its level bit.
// - Level bits have no fixed reset value and upper bits are reserved and read zero.
`timescale 1ns/10ps

module eight_bit_gpio_port
    import gpio_port_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          bus_sel,
    input  wire logic                          bus_wr,
    input  wire logic [gpio_port_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [gpio_port_pkg::DATA_W-1:0] bus_wdata,
    output logic      [gpio_port_pkg::DATA_W-1:0] bus_rdata,
    output logic                               bus_ack,
    input  wire logic [7:0]                    pin_in,
    output logic      [7:0]                    pin_out,
    output logic      [7:0]                    pin_oe_n,
    input  wire logic                          serial_tx_clock,
    input  wire logic                          serial_tx_frame_sync,
    output logic                               serial_mode
);

    // ********************************************
    // State
    // ********************************************
    logic [7:0]            port_direction;
    logic [7:0]            next_port_direction;
    logic [7:0]            port_level;
    logic [7:0]            next_port_level;
    logic [7:0]            sync_a;
    logic [7:0]            sync_b;
    logic                  strap_a;
    logic                  strap_b;
    pad_mode_t             pad_mode;
    pad_mode_t             next_pad_mode;
    logic                  next_serial_mode;
    logic [DATA_W-1:0]     next_rdata;
    logic                  next_ack;
    logic [7:0]            next_out;
    logic [7:0]            next_oe_n;
    logic [7:0]            read_level;
    logic                  wr_direction;
    logic                  wr_level;
    logic                  rd_direction;
    logic                  rd_level;

    // ********************************************
    // Decoding
    // ********************************************
    // Tells whether the bus address selects the given register.
    function automatic logic hits(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        return addr == offset;
    endfunction

    // Any other address is ignored on a write and reads as zero.
    always_comb begin
        wr_direction = bus_sel && bus_wr && hits(bus_addr, PORT_DIRECTION_ADR);
        wr_level     = bus_sel && bus_wr && hits(bus_addr, PORT_LEVEL_ADR);
        rd_direction = bus_sel && !bus_wr && hits(bus_addr, PORT_DIRECTION_ADR);
        rd_level     = bus_sel && !bus_wr && hits(bus_addr, PORT_LEVEL_ADR);
    end

    // ********************************************
    // Synchronisers
    // ********************************************
    // Pin levels are asynchronous, so only the second stage is read.
    always_ff @(posedge ref_clk) begin
        sync_a  <= pin_in;
        sync_b  <= sync_a;
        strap_a <= pin_in[STRAP_PIN];
        strap_b <= strap_a;
    end

    // ********************************************
    // Direction register
    // ********************************************
    always_comb begin
        next_port_direction = port_direction;
        if (wr_direction) begin
            next_port_direction = bus_wdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_direction <= DIRECTION_RESET;
        end else begin
            port_direction <= next_port_direction;
        end
    end

    // ********************************************
    // Level register
    // ********************************************
    always_comb begin
        next_port_level = port_level;
        if (wr_level) begin
            next_port_level = bus_wdata[PIN_MSB:PIN_LSB];
        end
    end

    // The level register has no fixed reset value; it takes the pins.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_level <= sync_b;
        end else begin
            port_level <= next_port_level;
        end
    end

    // ********************************************
    // Pad function
    // ********************************************
    // The strap is followed while reset is held, so the mode that is
    // left at release is the strap seen last during reset.
    always_comb begin
        next_pad_mode = pad_mode;
        if (sys_rst) begin
            next_pad_mode = strap_b ? PAD_SERIAL : PAD_PORT;
        end
        next_serial_mode = next_pad_mode == PAD_SERIAL;
    end

    always_ff @(posedge ref_clk) begin
        pad_mode    <= next_pad_mode;
        serial_mode <= next_serial_mode;
    end

    // ********************************************
    // Bus answer
    // ********************************************
    always_comb begin
        next_ack   = bus_sel;
        next_rdata = {DATA_W{1'b0}};
        for (int i = PIN_LSB; i <= PIN_MSB; i++) begin
            read_level[i] = port_direction[i] ? port_level[i] : sync_b[i];
        end
        if (rd_direction) begin
            next_rdata = {RESERVED_READ, port_direction};
        end else if (rd_level) begin
            next_rdata = {RESERVED_READ, read_level};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_rdata <= {DATA_W{1'b0}};
            bus_ack   <= 1'b0;
        end else begin
            bus_rdata <= next_rdata;
            bus_ack   <= next_ack;
        end
    end

    // ********************************************
    // Pad drivers
    // ********************************************
    // In serial mode the shared pads follow the serial signals whatever
    // their direction bits hold.
    always_comb begin
        for (int i = PIN_LSB; i <= PIN_MSB; i++) begin
            next_out[i]  = port_level[i];
            next_oe_n[i] = !port_direction[i];
        end
        if (pad_mode == PAD_SERIAL) begin
            next_out[PIN_THREE]  = serial_tx_clock;
            next_out[PIN_FIVE]   = serial_tx_frame_sync;
            next_oe_n[PIN_THREE] = 1'b0;
            next_oe_n[PIN_FIVE]  = 1'b0;
        end
    end

    // All pads float while reset is held.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_out  <= LEVEL_RESET;
            pin_oe_n <= ENABLE_RESET;
        end else begin
            pin_out  <= next_out;
            pin_oe_n <= next_oe_n;
        end
    end

endmodule

// ===== rtl/gpio_port_pkg.sv
// Package of register map, field layout and reset values for the eight-pin port.
package gpio_port_pkg;

    // ********************************************
    // Register map
    // ********************************************
    localparam int          ADDR_W             = 16;
    localparam int          DATA_W             = 16;
    localparam int          PIN_COUNT          = 8;
    localparam logic [15:0] PORT_DIRECTION_ADR = 16'h3400;
    localparam logic [15:0] PORT_LEVEL_ADR     = 16'h3401;

    // ********************************************
    // Fields and reset values
    // ********************************************
    localparam int          PIN_LSB            = 0;
    localparam int          PIN_MSB            = 7;
    localparam int          PIN_THREE          = 3;
    localparam int          PIN_FIVE           = 5;
    localparam int          STRAP_PIN          = 7;
    localparam logic [7:0]  DIRECTION_RESET    = 8'h00;
    localparam logic [7:0]  RESERVED_READ      = 8'h00;
    localparam logic [7:0]  LEVEL_RESET        = 8'h00;
    localparam logic [7:0]  ENABLE_RESET       = 8'hff;

    typedef enum logic [1:0] {
        PAD_PORT   = 2'b01,
        PAD_SERIAL = 2'b10
    } pad_mode_t;

endpackage

// ===== sim/board_pins.sv
// Board model that drives free pads and reads back driven ones.
`timescale 1ns/10ps
module board_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] drive,
    output logic      [7:0] pin_in
);
    // A driven pad shows the port value, a free pad the board level.
    assign pin_in = (pin_out & ~pin_oe_n) | (drive & pin_oe_n);
endmodule

// ===== sim/gpio_chk_assertions.sv
// Checker of bus answers, reserved bits, readback and pad mode.
`timescale 1ns/10ps
module gpio_chk (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        bus_sel,
    input wire logic        bus_wr,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_ack,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe_n,
    input wire logic        serial_mode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_ack_follows: assert property (bus_sel |=> bus_ack) else $error("ack missing");
    a_ack_stray: assert property (!bus_sel |=> !bus_ack) else $error("stray ack");
    a_dir_upper: assert property (bus_sel && !bus_wr && bus_addr == 16'h3400
        |=> bus_rdata[15:8] == 8'h00) else $error("direction upper bits set");
    a_level_upper: assert property (bus_sel && !bus_wr && bus_addr == 16'h3401
        |=> bus_rdata[15:8] == 8'h00) else $error("level upper bits set");
    a_unmapped_zero: assert property (bus_sel && (bus_wr || bus_addr[15:1] != 15'h1a00)
        |=> bus_rdata == 16'h0000) else $error("rdata not zero");
    a_dir_readback: assert property (bus_sel && !bus_wr && bus_addr == 16'h3400
        |=> bus_rdata[2:0] == ~pin_oe_n[2:0]) else $error("direction differs from enables");
    a_out_readback: assert property (bus_sel && !bus_wr && bus_addr == 16'h3401
        |=> (bus_rdata[2:0] & ~pin_oe_n[2:0]) == (pin_out[2:0] & ~pin_oe_n[2:0]))
        else $error("level differs from drive");
    a_mode_fixed: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
        |-> $stable(serial_mode)) else $error("pad mode changed");
    c_write: cover property (bus_sel && bus_wr);
    c_read: cover property (bus_sel && !bus_wr);
    c_serial: cover property (serial_mode);
endmodule
bind eight_bit_gpio_port gpio_chk u_chk (.*);

// ===== sim/test_eight_bit_gpio_port.sv
// Testbench of the eight-pin port.
`timescale 1ns/10ps
module test_eight_bit_gpio_port;
    import gpio_port_pkg::*;
    logic ref_clk = 0, sys_rst = 1, bus_sel = 0, bus_wr = 0, bus_ack, serial_mode;
    logic serial_tx_clock = 0, serial_tx_frame_sync = 0;
    logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe_n, drive = 8'h00;
    int failures = 0, checks = 0;
    eight_bit_gpio_port u_dut (.*);
    board_pins u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drive), .pin_in(pin_in));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [15:0] exp, got);
        checks++;
        if (exp !== got) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, d);
        @(negedge ref_clk);
        {bus_sel, bus_wr, bus_addr, bus_wdata} = {1'b1, wr, a, d};
        @(negedge ref_clk);
        bus_sel = 0;
        rd = bus_rdata;
        chk("ack", 16'h0001, {15'h0000, bus_ack});
    endtask
    task automatic do_reset(input logic strap);
        {sys_rst, drive} = {1'b1, strap, 7'h25};
        repeat (4) @(negedge ref_clk);
        sys_rst = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic t_reset;
        do_reset(0);
        chk("mode", 16'h0000, {15'h0000, serial_mode});
        bus(0, 16'h3400, 16'h0000); chk("dir", 16'h0000, rd);
        bus(0, 16'h3401, 16'h0000); chk("level", 16'h0025, rd);
    endtask
    task automatic t_dir_out;
        bus(1, 16'h3400, 16'hff0f);
        bus(0, 16'h3400, 16'h0000); chk("dir", 16'h000f, rd);
        bus(1, 16'h3401, 16'hff09);
        repeat (2) @(negedge ref_clk);
        chk("pins", 16'h0029, {8'h00, pin_in});
        chk("enables", 16'h00f0, {8'h00, pin_oe_n});
        bus(0, 16'h3401, 16'h0000); chk("level", 16'h0029, rd);
    endtask
    task automatic t_input;
        bus(1, 16'h3400, 16'h0000);
        drive = 8'h5a;
        repeat (2) @(negedge ref_clk);
        bus(0, 16'h3401, 16'h0000); chk("level", 16'h005a, rd);
    endtask
    task automatic t_unmapped;
        bus(1, 16'h3402, 16'hffff);
        bus(0, 16'h3402, 16'h0000); chk("unmapped", 16'h0000, rd);
        bus(0, 16'h3400, 16'h0000); chk("dir", 16'h0000, rd);
    endtask
    task automatic t_serial;
        do_reset(1);
        drive = 8'h00;
        {serial_tx_clock, serial_tx_frame_sync} = 2'b10;
        repeat (3) @(negedge ref_clk);
        chk("mode", 16'h0001, {15'h0000, serial_mode});
        chk("pads", 16'h0001, {14'h0000, pin_out[5], pin_out[3]});
        chk("enables", 16'h00d7, {8'h00, pin_oe_n});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        tally_and_finish;
    end
    initial begin
        t_reset;
        t_dir_out;
        t_input;
        t_unmapped;
        t_serial;
        tally_and_finish;
    end
endmodule
